// [vic_top.sv]
// Vectored interrupt controller with APB register access.
// Assumes the core samples take_irq with the vector and pushes its pc
// only when stack_full is low; peripherals pulse their source events.
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/100ps
module vic_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_irq_pin_a,
  input wire logic ext_irq_pin_b,
  input wire logic pull_high_a,
  input wire logic pull_high_b,
  output logic pull_high_a_out,
  output logic pull_high_b_out,
  input wire logic [1:0] ev_group0,
  input wire logic [1:0] ev_group1,
  input wire logic [1:0] ev_group2,
  input wire logic [2:0] ev_group3,
  input wire logic [2:0] ev_group4,
  input wire logic [1:0] ev_group5,
  input wire logic stack_full,
  input wire logic return_from_isr,
  input wire logic [12:0] pc_next,
  output logic take_irq,
  output logic [3:0] vector_num,
  output logic [12:0] pc_push,
  output logic pc_pop,
  output logic wake_up
);

  // ***************************************************************
  // Bus decode
  // ***************************************************************
  // Zero wait states; byte lane 0 must be strobed to change a register.
  wire bus_wr = psel & penable & pwrite & pstrb[0];
  wire bus_rd = psel & ~pwrite;
  wire sel_edge = (paddr == vic_pkg::OFF_EDGE_SELECT);
  wire sel_pri = (paddr == vic_pkg::OFF_PRIMARY);
  wire sel_ctrl = (paddr == vic_pkg::OFF_GROUP_CTRL);
  wire sel_stat = (paddr == vic_pkg::OFF_STATUS);
  wire [5:0] sel_grp;
  assign sel_grp[0] = (paddr == vic_pkg::OFF_GROUP0);
  assign sel_grp[1] = (paddr == vic_pkg::OFF_GROUP1);
  assign sel_grp[2] = (paddr == vic_pkg::OFF_GROUP2);
  assign sel_grp[3] = (paddr == vic_pkg::OFF_GROUP3);
  assign sel_grp[4] = (paddr == vic_pkg::OFF_GROUP4);
  assign sel_grp[5] = (paddr == vic_pkg::OFF_GROUP5);
  wire mapped = sel_edge | sel_pri | sel_ctrl | sel_stat | (|sel_grp);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ***************************************************************
  // Registers and state
  // ***************************************************************
  logic [7:0] edge_select_reg;
  logic [7:0] primary_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] grp_reg [6];
  logic [1:0] pin_prev_reg;
  logic take_reg;
  logic [3:0] vec_reg;
  logic [12:0] pc_reg;
  logic pop_reg;
  logic wake_reg;

  // Mask of writable bits per group: groups 3 and 4 carry three sources.
  // Group register layouts.
  function automatic logic [7:0] grp_mask(input int g);
    grp_mask = (g == 3 || g == 4) ? vic_pkg::GROUP_MASK_3SRC :
                                    vic_pkg::GROUP_MASK_2SRC;
  endfunction

  // Source events placed at their flag bits.
  wire [7:0] ev_bits [6];
  assign ev_bits[0] = {2'h0, ev_group0, 4'h0};
  assign ev_bits[1] = {2'h0, ev_group1, 4'h0};
  assign ev_bits[2] = {2'h0, ev_group2, 4'h0};
  assign ev_bits[3] = {1'b0, ev_group3, 4'h0};
  assign ev_bits[4] = {1'b0, ev_group4, 4'h0};
  assign ev_bits[5] = {2'h0, ev_group5, 4'h0};

  // ***************************************************************
  // External pin edge detection
  // ***************************************************************
  // Edge select resets to off, so a pin held high at reset cannot fire.
  // Edge field decode.
  wire [1:0] pin_now = {ext_irq_pin_b, ext_irq_pin_a};
  wire [1:0] pin_hit;
  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_pin
      wire [1:0] sel = edge_select_reg[2*p +: 2];
      wire rise = pin_now[p] & ~pin_prev_reg[p];
      wire fall = ~pin_now[p] & pin_prev_reg[p];
      assign pin_hit[p] = (sel == vic_pkg::EDGE_RISE && rise) ||
                          (sel == vic_pkg::EDGE_FALL && fall) ||
                          (sel == vic_pkg::EDGE_BOTH && (rise | fall));
    end
  endgenerate

  // Pull-high selection passes straight to the pad.
  assign pull_high_a_out = pull_high_a;
  assign pull_high_b_out = pull_high_b;

  // ***************************************************************
  // Request qualification and priority
  // ***************************************************************
  // A group has a source hit if any member source is both flagged and enabled.
  wire [5:0] grp_src_hit;
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_grp
      wire [7:0] src_mask = grp_mask(g);
      assign grp_src_hit[g] =
        |(grp_reg[g][6:4] & grp_reg[g][2:0] & src_mask[2:0]);
    end
  endgenerate
  // Groups 3 to 5 keep their group flags and enables in the control reg.
  wire [5:0] grp_flag = {ctrl_reg[6:4], 3'h0};
  wire [5:0] grp_en = {ctrl_reg[2:0], 3'h0};
  // Groups 0-2 flag/enable sit in primary bits the core owns elsewhere;
  // here the flags are kept in the status-side shadow below; the enables are held on.
  logic [2:0] low_flag_reg;
  logic [2:0] low_en_reg;
  wire [5:0] g_flag = grp_flag | {3'h0, low_flag_reg};
  wire [5:0] g_en = grp_en | {3'h0, low_en_reg};
  // Vector needs group flag, group enable and a source enable.
  wire [5:0] grp_req = g_flag & g_en & grp_src_hit;
  wire pin_a_req = primary_reg[vic_pkg::PRI_PIN_A_FLAG_BIT] &
                   primary_reg[vic_pkg::PRI_PIN_A_EN_BIT];
  wire pin_b_req = primary_reg[vic_pkg::PRI_PIN_B_FLAG_BIT] &
                   primary_reg[vic_pkg::PRI_PIN_B_EN_BIT];
  wire [7:0] req_vec = {grp_req, pin_b_req, pin_a_req};
  wire global_en = primary_reg[vic_pkg::PRI_GLOBAL_BIT];
  // Holding off while take_irq is high keeps one pick per entry pulse.
  // Global gate.
  wire can_take = global_en & ~stack_full & (|req_vec) & ~take_reg;

  logic [2:0] win_idx;
  always_comb begin
    win_idx = 3'h0;
    for (int i = vic_pkg::NUM_VEC - 1; i >= 0; i--) begin
      if (req_vec[i]) begin
        win_idx = 3'(i);
      end
    end
  end
  wire [3:0] win_vec = vic_pkg::VEC_PIN_A + {1'b0, win_idx};
  wire [7:0] win_onehot = can_take ? (8'h01 << win_idx) : 8'h00;

  // ***************************************************************
  // Register update
  // ***************************************************************
  // Hardware sets win over a same-cycle software clear throughout.
  // Events always set flags.
  // Flags record even with global enable low.
  wire [7:0] edge_next = (bus_wr && sel_edge) ?
                         (pwdata[7:0] & vic_pkg::EDGE_MASK) : edge_select_reg;
  wire [7:0] pri_wr = (bus_wr && sel_pri) ?
                      (pwdata[7:0] & vic_pkg::PRIMARY_MASK) : primary_reg;
  wire [7:0] pri_clr = {1'b0, ~win_onehot[1], ~win_onehot[0], 4'hF,
                        ~can_take};
  wire [7:0] primary_next = (pri_wr & pri_clr) |
                            {1'b0, pin_hit, 5'h00};
  wire [2:0] low_clr = win_onehot[4:2];
  wire [2:0] ctrl_clr = win_onehot[7:5];
  wire [7:0] ctrl_wr = (bus_wr && sel_ctrl) ?
                       (pwdata[7:0] & vic_pkg::CTRL_MASK) : ctrl_reg;
  wire [5:0] grp_set;
  generate
    for (g = 0; g < 6; g++) begin : g_set
      assign grp_set[g] = |ev_bits[g];
    end
  endgenerate
  // Control bits 7 and 3 stay zero.
  wire [7:0] ctrl_next = {1'b0, (ctrl_wr[6:4] & ~ctrl_clr) | grp_set[5:3],
                          1'b0, ctrl_wr[2:0]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_select_reg <= vic_pkg::RESET_BYTE;
      primary_reg <= vic_pkg::RESET_BYTE;
      ctrl_reg <= vic_pkg::RESET_BYTE;
      pin_prev_reg <= 2'h0;
      low_flag_reg <= 3'h0;
      low_en_reg <= 3'h0;
    end else begin
      edge_select_reg <= edge_next;
      primary_reg <= primary_next;
      ctrl_reg <= ctrl_next;
      pin_prev_reg <= pin_now;
      low_flag_reg <= (low_flag_reg & ~low_clr) | grp_set[2:0];
      low_en_reg <= 3'h7;
    end
  end

  // Source flags only cleared by software writes.
  generate
    for (g = 0; g < 6; g++) begin : g_src
      wire [7:0] wr_val = (bus_wr && sel_grp[g]) ?
                          (pwdata[7:0] & grp_mask(g)) : grp_reg[g];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          grp_reg[g] <= vic_pkg::RESET_BYTE;
        end else begin
          grp_reg[g] <= wr_val | ev_bits[g];
        end
      end
    end
  endgenerate

  // ***************************************************************
  // Core handshake
  // ***************************************************************
  // Push pc and present the vector.
  // Wake on any flag newly set by a source event or pin edge.
  wire any_set = (|grp_set) | (|pin_hit);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      take_reg <= 1'b0;
      vec_reg <= 4'h0;
      pc_reg <= 13'h0000;
      pop_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      take_reg <= can_take;
      vec_reg <= can_take ? win_vec : vec_reg;
      pc_reg <= can_take ? pc_next : pc_reg;
      pop_reg <= return_from_isr;
      wake_reg <= any_set;
    end
  end
  assign take_irq = take_reg;
  assign vector_num = vec_reg;
  assign pc_push = pc_reg;
  assign pc_pop = pop_reg;
  assign wake_up = wake_reg;

  // ***************************************************************
  // Read mux
  // ***************************************************************
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (sel_edge) rd_byte = edge_select_reg;
    if (sel_pri) rd_byte = primary_reg;
    if (sel_ctrl) rd_byte = ctrl_reg;
    if (sel_stat) rd_byte = {1'b0, low_flag_reg, 1'b0, vec_reg[2:0]};
    for (int i = 0; i < vic_pkg::NUM_GROUPS; i++) begin
      if (sel_grp[i]) rd_byte = grp_reg[i];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (bus_rd && !penable) begin
      prdata <= {24'h00_0000, rd_byte};
    end
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_global_gate: assert property (take_irq |-> $past(global_en))
    else $error("Interrupt taken with global enable low.");
  a_global_clear: assert property (take_irq |-> !global_en)
    else $error("Global enable not cleared on entry.");
  a_stack_hold: assert property (take_irq |-> !$past(stack_full))
    else $error("Interrupt taken while stack full.");
  a_source_kept: assert property (can_take && grp_reg[3][6] &&
    !bus_wr |=> grp_reg[3][6])
    else $error("Source flag cleared by service.");
  a_event_sets: assert property (ev_group1[0] |=> grp_reg[1][4])
    else $error("Event did not set flag.");
  a_pin_rise: assert property (edge_select_reg[1:0] == 2'h1 &&
    !pin_prev_reg[0] && ext_irq_pin_a |=> primary_reg[5])
    else $error("Rising edge missed.");
  a_pin_off: assert property (edge_select_reg[1:0] == 2'h0 |->
    !pin_hit[0])
    else $error("Disabled pin triggered.");
  a_pin_priority: assert property (can_take && pin_a_req |=>
    vector_num == vic_pkg::VEC_PIN_A)
    else $error("Pin A lost priority.");
  a_pop_follow: assert property (return_from_isr |=> pc_pop)
    else $error("Pop missing.");
  a_wake_flag: assert property (|ev_group3 |=> wake_up)
    else $error("Wake missing.");

  // Service side effects: the pc goes to the stack and the winner's flag
  // clears (pin A, group three), checked in cycles with no new edge or event for that flag.
  a_push_pc: assert property (can_take |=>
    pc_push == $past(pc_next))
    else $error("Pushed pc differs from the offered pc.");
  a_pin_a_clear: assert property (can_take && win_onehot[0] &&
    !pin_hit[0] |=> !primary_reg[vic_pkg::PRI_PIN_A_FLAG_BIT])
    else $error("Pin A flag not cleared on service.");
  a_group_clear: assert property (can_take && win_onehot[5] &&
    !grp_set[3] |=> !ctrl_reg[4])
    else $error("Group three flag not cleared on service.");

  // Recording, gating, vector numbering and edge decode of requests; wake on a pin edge.
  a_flag_hold: assert property (ev_group3[2] && !global_en |=>
    grp_reg[3][6])
    else $error("Request lost while global enable low.");
  a_enable_gate: assert property (take_irq &&
    vector_num == vic_pkg::VEC_GROUP0 + 4'h1 |-> $past(grp_src_hit[1]))
    else $error("Group one taken without an enabled source.");
  a_group5_alone: assert property (can_take && req_vec == 8'h80 |=>
    vector_num == vic_pkg::VEC_GROUP0 + 4'h5)
    else $error("Lone group five request got a wrong vector.");
  a_pin_fall: assert property (edge_select_reg[1:0] == 2'h2 &&
    pin_prev_reg[0] && !ext_irq_pin_a |=> primary_reg[5])
    else $error("Falling edge missed.");
  a_pin_b_both: assert property (edge_select_reg[3:2] == 2'h3 &&
    pin_prev_reg[1] != ext_irq_pin_b |=> primary_reg[6])
    else $error("Pin B edge missed with both edges selected.");
  a_wake_pin: assert property (|pin_hit |=> wake_up)
    else $error("Wake missing after pin edge.");

  c_take: cover property (take_irq);
  c_group_take: cover property (take_irq && vector_num > 4'h2);
  c_stack_block: cover property (stack_full && |req_vec && global_en);
  c_pin_take: cover property (take_irq && vector_num == vic_pkg::VEC_PIN_A);
  c_wake_idle: cover property (wake_up && !global_en);
endmodule

// [vic_pkg.sv]
// Package for the vectored interrupt controller.
// Assumes a 32-bit APB slave at 25 MHz; registers sit in the low byte.
package vic_pkg;

  // ***************************************************************
  // Register offsets (byte addresses)
  // ***************************************************************
  localparam logic [11:0] OFF_EDGE_SELECT = 12'h000;
  localparam logic [11:0] OFF_PRIMARY = 12'h004;
  localparam logic [11:0] OFF_GROUP_CTRL = 12'h008;
  localparam logic [11:0] OFF_GROUP0 = 12'h00C;
  localparam logic [11:0] OFF_GROUP1 = 12'h010;
  localparam logic [11:0] OFF_GROUP2 = 12'h014;
  localparam logic [11:0] OFF_GROUP3 = 12'h018;
  localparam logic [11:0] OFF_GROUP4 = 12'h01C;
  localparam logic [11:0] OFF_GROUP5 = 12'h020;
  localparam logic [11:0] OFF_STATUS = 12'h024;

  // ***************************************************************
  // Field layouts and reset values
  // ***************************************************************
  localparam int FLAG_LSB = 4;
  localparam logic [7:0] GROUP_MASK_2SRC = 8'h33;
  localparam logic [7:0] GROUP_MASK_3SRC = 8'h77;
  localparam logic [7:0] CTRL_MASK = 8'h77;
  localparam logic [7:0] EDGE_MASK = 8'h0F;
  localparam logic [7:0] PRIMARY_MASK = 8'h6D;
  localparam int PRI_GLOBAL_BIT = 0;
  localparam int PRI_PIN_A_EN_BIT = 2;
  localparam int PRI_PIN_B_EN_BIT = 3;
  localparam int PRI_PIN_A_FLAG_BIT = 5;
  localparam int PRI_PIN_B_FLAG_BIT = 6;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Edge select encodings.
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Vector numbers: lower number wins.
  localparam logic [3:0] VEC_PIN_A = 4'h1;
  localparam logic [3:0] VEC_PIN_B = 4'h2;
  localparam logic [3:0] VEC_GROUP0 = 4'h3;
  localparam int NUM_GROUPS = 6;
  localparam int NUM_VEC = 8;
endpackage

// [vic_core_model.sv]
// Core-side model: stack state and return path of the sequencer.
// Assumes the controller pulses take_irq once per entry.
`timescale 1ns/100ps
module vic_core_model #(
  parameter int RET_DLY = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic full_req,
  input wire logic take_irq,
  input wire logic pc_pop,
  output logic stack_full,
  output logic return_from_isr,
  output logic [12:0] pc_next,
  output int n_pop
);
  int cnt;

  assign stack_full = full_req;
  // pc held still, so the pushed value is known.
  assign pc_next = 13'h0ABC;

  // return after service
  // The return is late on purpose, so a pop can only follow it.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      return_from_isr <= 1'b0;
      n_pop <= 0;
    end else begin
      return_from_isr <= (cnt == 1);
      if (take_irq === 1'b1)
        cnt <= RET_DLY;
      else if (cnt > 0)
        cnt <= cnt - 1;
      if (pc_pop === 1'b1)
        n_pop <= n_pop + 1;
    end
  end
endmodule

// [vectored_interrupt_controller_test.sv]
// Self-checking bench for the vectored interrupt controller.
// Assumes the core model answers every entry with a return pulse.
`timescale 1ns/100ps
module vectored_interrupt_controller_test;
  // ***************************************************************
  // Signals and instances
  // ***************************************************************
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, vector_num;
  logic ext_irq_pin_a, ext_irq_pin_b, pull_high_a, pull_high_b;
  logic pull_high_a_out, pull_high_b_out, full_req, stack_full;
  logic [1:0] ev_group0, ev_group1, ev_group2, ev_group5;
  logic [2:0] ev_group3, ev_group4;
  logic return_from_isr, take_irq, pc_pop, wake_up;
  logic [12:0] pc_next, pc_push;
  int n_fail, checked, n_pop, i;
  logic [11:0] offs [7] = '{vic_pkg::OFF_GROUP_CTRL,
    vic_pkg::OFF_GROUP0, vic_pkg::OFF_GROUP1, vic_pkg::OFF_GROUP2,
    vic_pkg::OFF_GROUP3, vic_pkg::OFF_GROUP4, vic_pkg::OFF_GROUP5};
  logic [7:0] masks [7] = '{8'h77, 8'h33, 8'h33, 8'h33, 8'h77, 8'h77,
    8'h33};

  vic_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .ext_irq_pin_a,
    .ext_irq_pin_b, .pull_high_a, .pull_high_b, .pull_high_a_out,
    .pull_high_b_out, .ev_group0, .ev_group1, .ev_group2, .ev_group3,
    .ev_group4, .ev_group5, .stack_full, .return_from_isr, .pc_next,
    .take_irq, .vector_num, .pc_push, .pc_pop, .wake_up);
  vic_core_model #(.RET_DLY(3)) core (.pclk, .presetn, .full_req,
    .take_irq, .pc_pop, .stack_full, .return_from_isr, .pc_next,
    .n_pop);

  // Free-running bus clock.
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // ***************************************************************
  // Tasks
  // ***************************************************************
  task automatic close_out();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer; request held until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (k == 20) begin
      n_fail++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e,
                       input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  // Watches take_irq (sel 0) or wake_up (sel 1) for a bounded time.
  task automatic watch(input logic sel, input string nm,
                       input logic [31:0] e);
    int k, s;
    s = 0;
    for (k = 0; k < 12; k++) begin
      @(posedge pclk);
      if ((sel ? wake_up : take_irq) === 1'b1)
        s = 1;
    end
    chk(nm, e, s);
  endtask

  task automatic take_chk(input logic [3:0] v, input string nm);
    int k;
    for (k = 0; k < 12 && take_irq !== 1'b1; k++)
      @(posedge pclk);
    if (k == 12) begin
      n_fail++;
      close_out();
    end
    chk(nm, {28'h0, v}, {28'h0, vector_num});
    chk("pc_push", 32'h0ABC, {19'h0, pc_push});
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  // A hang anywhere ends the run as a failure.
  initial begin
    #2000000;
    n_fail++;
    close_out();
  end

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    {ext_irq_pin_a, ext_irq_pin_b, pull_high_a, pull_high_b} = '0;
    {ev_group0, ev_group1, ev_group2, ev_group5} = '0;
    {ev_group3, ev_group4, full_req} = '0;
    pstrb = 4'hF;
    do_reset();
    for (i = 0; i < 7; i++)
      rdchk(offs[i], 32'h0, "reset value");
    // Reserved bits must stay zero whatever is written.
    for (i = 0; i < 7; i++) begin
      wr_loop: apb(1'b1, offs[i], 32'hFF);
      rdchk(offs[i], {24'h0, masks[i]}, "mask");
    end
    apb(1'b1, 12'h0FC, 32'hFF);
    chk("pslverr", 32'h1, {31'h0, err});
    rdchk(12'h0FC, 32'h0, "unmapped read");
    do_reset();
    $display("test registers done");

    // Both pins share each edge code; flags land at bits 5 and 6.
    for (i = 0; i < 4; i++) begin
      apb(1'b1, vic_pkg::OFF_EDGE_SELECT, {28'h0, i[1:0], i[1:0]});
      {ext_irq_pin_a, ext_irq_pin_b} <= 2'b11;
      repeat (4) @(posedge pclk);
      rdchk(vic_pkg::OFF_PRIMARY, i[0] ? 32'h60 : 32'h0, "rise");
      apb(1'b1, vic_pkg::OFF_PRIMARY, 32'h0);
      {ext_irq_pin_a, ext_irq_pin_b} <= 2'b00;
      repeat (4) @(posedge pclk);
      rdchk(vic_pkg::OFF_PRIMARY, i[1] ? 32'h60 : 32'h0, "fall");
      apb(1'b1, vic_pkg::OFF_PRIMARY, 32'h0);
    end
    $display("test edges done");

    // A disabled source still latches and wakes, but never vectors.
    ev_group1 <= 2'b10;
    @(posedge pclk);
    ev_group1 <= 2'b00;
    watch(1'b1, "wake_up", 32'h1);
    rdchk(vic_pkg::OFF_GROUP1, 32'h20, "group1 flag");
    apb(1'b1, vic_pkg::OFF_PRIMARY, 32'h1);
    watch(1'b0, "take masked", 32'h0);
    apb(1'b1, vic_pkg::OFF_PRIMARY, 32'h0);
    apb(1'b1, vic_pkg::OFF_GROUP1, 32'h22);
    watch(1'b0, "take global off", 32'h0);
    apb(1'b1, vic_pkg::OFF_PRIMARY, 32'h1);
    take_chk(4'h4, "vector group1");
    rdchk(vic_pkg::OFF_PRIMARY, 32'h0, "global after entry");
    rdchk(vic_pkg::OFF_GROUP1, 32'h22, "group1 after entry");
    apb(1'b1, vic_pkg::OFF_PRIMARY, 32'h1);
    watch(1'b0, "take repeated", 32'h0);
    apb(1'b1, vic_pkg::OFF_PRIMARY, 32'h0);
    apb(1'b1, vic_pkg::OFF_GROUP1, 32'h0);
    $display("test enables done");

    // A full stack holds the request off until it drains.
    full_req <= 1'b1;
    apb(1'b1, vic_pkg::OFF_GROUP_CTRL, 32'h1);
    apb(1'b1, vic_pkg::OFF_GROUP3, 32'h4);
    ev_group3 <= 3'b100;
    @(posedge pclk);
    ev_group3 <= 3'b000;
    apb(1'b1, vic_pkg::OFF_PRIMARY, 32'h1);
    watch(1'b0, "take stack full", 32'h0);
    full_req <= 1'b0;
    take_chk(4'h6, "vector group3");
    rdchk(vic_pkg::OFF_GROUP_CTRL, 32'h1, "group3 request");
    rdchk(vic_pkg::OFF_GROUP3, 32'h44, "group3 sources");
    apb(1'b1, vic_pkg::OFF_GROUP3, 32'h0);
    $display("test stack done");

    // Pin a and group 5 pending together: pin a goes first.
    apb(1'b1, vic_pkg::OFF_EDGE_SELECT, 32'h1);
    apb(1'b1, vic_pkg::OFF_PRIMARY, 32'h4);
    apb(1'b1, vic_pkg::OFF_GROUP_CTRL, 32'h4);
    apb(1'b1, vic_pkg::OFF_GROUP5, 32'h1);
    ev_group5 <= 2'b01;
    ext_irq_pin_a <= 1'b1;
    @(posedge pclk);
    ev_group5 <= 2'b00;
    repeat (4) @(posedge pclk);
    // The write keeps the pin A flag at one, or it would wipe the request.
    apb(1'b1, vic_pkg::OFF_PRIMARY, 32'h25);
    take_chk(4'h1, "vector pin a");
    rdchk(vic_pkg::OFF_PRIMARY, 32'h4, "pin a flag");
    apb(1'b1, vic_pkg::OFF_PRIMARY, 32'h5);
    take_chk(4'h8, "vector group5");
    repeat (8) @(posedge pclk);
    chk("pops", 32'h4, n_pop);
    $display("test priority done");

    // Pull-high selections pass straight through.
    for (i = 1; i < 3; i++) begin
      {pull_high_a, pull_high_b} <= i[1:0];
      repeat (2) @(posedge pclk);
      chk("pull_high", i, {pull_high_a_out, pull_high_b_out});
    end
    $display("test pull-high done");
    close_out();
  end
endmodule
